// ---- logic/llc_top.sv ----
// line loop-code detection, remote loopback and fifo limit status
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "llc_cfg.svh"

// two-flop synchroniser for words from another clock domain
module llc_sync2
    import llc_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } llc_sync_t;

    llc_sync_t s_q;
    llc_sync_t s_d;

    // only the second stage is read, the first may still be settling
    assign q_out = s_q.held;

    always_comb
    begin
        s_d      = s_q;
        s_d.meta = d_in;
        s_d.held = s_q.meta;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

endmodule : llc_sync2

module llc_top
    import llc_pkg::*;
#(
    parameter int QUAL_BITS = `LLC_QUAL_BITS
)(
    input  wire logic        CLK_SYS_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        LINE_CLK_IN,
    input  wire logic        LINE_DATA_IN,
    input  wire logic [5:0]  FIFO_WR_PTR_IN,
    input  wire logic [5:0]  FIFO_RD_PTR_IN,
    output logic             REMOTE_LOOPBACK_OUT,
    output logic             IRQ_OUT,
    input  wire logic [11:0] AWADDR_IN,
    input  wire logic        AWVALID_IN,
    output logic             AWREADY_OUT,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic [3:0]  WSTRB_IN,
    input  wire logic        WVALID_IN,
    output logic             WREADY_OUT,
    output logic [1:0]       BRESP_OUT,
    output logic             BVALID_OUT,
    input  wire logic        BREADY_IN,
    input  wire logic [11:0] ARADDR_IN,
    input  wire logic        ARVALID_IN,
    output logic             ARREADY_OUT,
    output logic [31:0]      RDATA_OUT,
    output logic [1:0]       RRESP_OUT,
    output logic             RVALID_OUT,
    input  wire logic        RREADY_IN
);

    llc_state_t s_q;
    llc_state_t s_d;

    logic       line_edge;
    logic       up_match;
    logic       down_match;
    logic       wr_fire;
    logic       rd_fire;
    logic [5:0] ptr_gap;
    logic [5:0] ptr_gap_abs;
    logic       fifo_near;
    logic       new_loop_flag;
    llc_mode_t  mode;
    logic [7:0] status_byte;
    logic [7:0] irq_byte;
    logic [23:0] qual_cnt;
    logic [5:0]  wr_ptr_sync;
    logic [5:0]  rd_ptr_sync;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic        wr_strobe_low;
    logic        wr_hit_enable;
    logic        wr_hit_mode;
    logic        wr_hit_status;
    logic        rd_hit_enable;
    logic        rd_hit_status;
    logic        rd_hit_irq;
    logic        rd_hit_mode;

    assign qual_cnt = 24'(QUAL_BITS);
    assign mode = llc_mode_t'(s_q.mode_q);
    assign line_edge = s_q.line_clk_sync[1] & ~s_q.line_clk_sync[2];

    // a code counts only while each new bit repeats the bit one period back
    assign up_match = (s_q.hist[4] == s_q.line_data_sync[1]) &&
                      ($countones(s_q.hist) == 1);
    assign down_match = (s_q.hist[2] == s_q.line_data_sync[1]) &&
                        (s_q.hist[2:0] != 3'h0) && (s_q.hist[2:0] != 3'h7) &&
                        ($countones(s_q.hist[2:0]) == 1);

    // a torn pointer word settles two cycles later; the flag may blink
    // once if both pointers move in the cycle they are sampled
    llc_sync2 #(
        .WIDTH (6)
    ) llc_sync2_wr_inst (
        .clk_in (CLK_SYS_IN),
        .rst_in (SYS_RST_IN),
        .d_in   (FIFO_WR_PTR_IN),
        .q_out  (wr_ptr_sync)
    );

    llc_sync2 #(
        .WIDTH (6)
    ) llc_sync2_rd_inst (
        .clk_in (CLK_SYS_IN),
        .rst_in (SYS_RST_IN),
        .d_in   (FIFO_RD_PTR_IN),
        .q_out  (rd_ptr_sync)
    );

    // the gap is taken modulo the fifo depth, either way round
    assign ptr_gap = wr_ptr_sync - rd_ptr_sync;
    assign ptr_gap_abs = ptr_gap[5] ? 6'(-ptr_gap) : ptr_gap;
    assign fifo_near = (ptr_gap_abs <= `LLC_FIFO_NEAR);

    assign status_byte = {2'b00, s_q.fifo_flag, 1'b0,
                          s_q.loop_flag, 3'b000};
    assign irq_byte = {2'b00, s_q.fl_latched, 1'b0, s_q.lc_latched, 3'b000};

    // address and data may arrive in either order; the earlier is buffered
    assign wr_addr = s_q.aw_pend ? s_q.aw_addr : AWADDR_IN;
    assign wr_data = s_q.w_pend ? s_q.w_data : WDATA_IN;
    // buffered data is kept whole, so its low lane counts as enabled
    assign wr_strobe_low = s_q.w_pend | WSTRB_IN[0];
    assign wr_hit_enable = (wr_addr[11:2] == 10'(`LLC_ADDR_ENABLE));
    assign wr_hit_mode = (wr_addr[11:2] == 10'(`LLC_ADDR_MODE));
    assign wr_hit_status = (wr_addr[11:2] == 10'(`LLC_ADDR_STATUS)) |
                           (wr_addr[11:2] == 10'(`LLC_ADDR_IRQ_STATUS));
    assign rd_hit_enable = (ARADDR_IN[11:2] == 10'(`LLC_ADDR_ENABLE));
    assign rd_hit_status = (ARADDR_IN[11:2] == 10'(`LLC_ADDR_STATUS));
    assign rd_hit_irq = (ARADDR_IN[11:2] == 10'(`LLC_ADDR_IRQ_STATUS));
    assign rd_hit_mode = (ARADDR_IN[11:2] == 10'(`LLC_ADDR_MODE));

    // ready drops while an answer waits, so one of each is under way
    assign AWREADY_OUT = ~s_q.aw_pend & ~s_q.bvalid;
    assign WREADY_OUT = ~s_q.w_pend & ~s_q.bvalid;
    assign ARREADY_OUT = ~s_q.rvalid;
    assign wr_fire = (s_q.aw_pend | AWVALID_IN) & (s_q.w_pend | WVALID_IN)
                     & ~s_q.bvalid;
    assign rd_fire = ARVALID_IN & ~s_q.rvalid;

    assign BVALID_OUT = s_q.bvalid;
    assign BRESP_OUT = s_q.bresp;
    assign RVALID_OUT = s_q.rvalid;
    assign RDATA_OUT = s_q.rdata;
    assign RRESP_OUT = s_q.rresp;
    assign REMOTE_LOOPBACK_OUT = s_q.loopback;
    assign IRQ_OUT = (s_q.lc_latched | s_q.fl_latched);

    always_comb
    begin
        s_d = s_q;
        new_loop_flag = s_q.loop_flag;

        s_d.line_clk_sync = {s_q.line_clk_sync[1:0], LINE_CLK_IN};
        s_d.line_data_sync = {s_q.line_data_sync[0], LINE_DATA_IN};
        s_d.fifo_flag = fifo_near;

        if (line_edge)
        begin
            s_d.hist = {s_q.hist[3:0], s_q.line_data_sync[1]};
            if (up_match)
            begin
                if (s_q.up_cnt < qual_cnt)
                    s_d.up_cnt = s_q.up_cnt + 24'h000001;
            end
            else
                s_d.up_cnt = 24'h000000;
            if (down_match)
            begin
                if (s_q.down_cnt < qual_cnt)
                    s_d.down_cnt = s_q.down_cnt + 24'h000001;
            end
            else
                s_d.down_cnt = 24'h000000;
        end
        s_d.up_seen = (s_q.up_cnt >= qual_cnt);
        s_d.down_seen = (s_q.down_cnt >= qual_cnt);

        case (mode)
            LLC_MAN_UP:
            begin
                new_loop_flag = s_q.up_seen;
                s_d.loopback = 1'b0;
            end
            LLC_MAN_DOWN:
            begin
                new_loop_flag = s_q.down_seen;
                s_d.loopback = 1'b0;
            end
            LLC_AUTO:
            begin
                case (s_q.auto_st)
                    LLC_AUTO_SEEK_UP:
                    begin
                        if (s_q.up_seen)
                        begin
                            new_loop_flag = 1'b1;
                            s_d.loopback = 1'b1;
                            s_d.auto_st = LLC_AUTO_LOOPED;
                        end
                    end
                    LLC_AUTO_LOOPED:
                    begin
                        new_loop_flag = 1'b1;
                        if (s_q.down_seen)
                        begin
                            new_loop_flag = 1'b0;
                            s_d.loopback = 1'b0;
                            s_d.auto_st = LLC_AUTO_SEEK_UP;
                        end
                    end
                    default:
                        s_d.auto_st = LLC_AUTO_SEEK_UP;
                endcase
            end
            default:
            begin
                new_loop_flag = 1'b0;
                s_d.loopback = 1'b0;
            end
        endcase

        s_d.aw_pend = s_q.aw_pend | (AWVALID_IN & AWREADY_OUT);
        if (AWVALID_IN & AWREADY_OUT)
            s_d.aw_addr = AWADDR_IN;
        s_d.w_pend = s_q.w_pend | (WVALID_IN & WREADY_OUT);
        if (WVALID_IN & WREADY_OUT)
            s_d.w_data = WDATA_IN;
        if (s_q.bvalid & BREADY_IN)
            s_d.bvalid = 1'b0;
        if (wr_fire)
        begin
            s_d.aw_pend = 1'b0;
            s_d.w_pend = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `LLC_RESP_OKAY;
            if (wr_hit_enable)
            begin
                if (wr_strobe_low)
                    s_d.enable = wr_data[7:0];
            end
            else if (wr_hit_mode)
                s_d.mode_q = wr_data[1:0];
            else if (wr_hit_status)
                s_d.bresp = `LLC_RESP_OKAY;
            else
                s_d.bresp = `LLC_RESP_SLVERR;
        end

        // entering automatic mode restarts the search for loop-up
        if (mode != LLC_AUTO && llc_mode_t'(s_d.mode_q) == LLC_AUTO)
        begin
            s_d.auto_st = LLC_AUTO_SEEK_UP;
            s_d.loopback = 1'b0;
            new_loop_flag = 1'b0;
        end
        s_d.loop_flag = new_loop_flag;

        if (s_q.rvalid & RREADY_IN)
            s_d.rvalid = 1'b0;
        if (rd_fire)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `LLC_RESP_OKAY;
            s_d.rdata = 32'h00000000;
            // reading the interrupt status hands it over and clears it
            if (rd_hit_enable)
                s_d.rdata = {24'h000000, s_q.enable};
            else if (rd_hit_status)
                s_d.rdata = {24'h000000, status_byte};
            else if (rd_hit_irq)
            begin
                s_d.rdata = {24'h000000, irq_byte};
                s_d.lc_latched = 1'b0;
                s_d.fl_latched = 1'b0;
            end
            else if (rd_hit_mode)
                s_d.rdata = {30'h00000000, s_q.mode_q};
            else
                s_d.rresp = `LLC_RESP_SLVERR;
        end

        // a change in the same cycle as the clearing read still latches
        if ((new_loop_flag != s_q.loop_flag) &&
            s_q.enable[`LLC_BIT_LOOP_CODE])
            s_d.lc_latched = 1'b1;
        if ((fifo_near != s_q.fifo_flag) &&
            s_q.enable[`LLC_BIT_FIFO_LIMIT])
            s_d.fl_latched = 1'b1;
    end

    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            s_q <= '0;
        else
        begin
            s_q <= s_d;
        end
    end

endmodule : llc_top
`default_nettype wire

// ---- logic/llc_cfg.svh ----
// register offsets, field positions, fifo limit, timing counts and response codes
// Contract
// - fifo limit flag while pointers within three
// - fifo limit change interrupts when enabled
// - status bit four always reads zero
// - manual loop-up: 00001 over 5 s sets flag
// - manual flag follows code, clears when lost
// - manual loop-down: 001 over 5 s sets flag
// - loop flag changes interrupt both directions
// - entering automatic mode clears flag, seeks loop-up
// - auto: loop-up 5 s sets flag, loopback on
// - auto: flag holds while loopback active
// - auto: loop-down 5 s ends loopback, clears flag
// - status flags are read-only, writes ignored
// - flag changes latch interrupt status bits
// - reading interrupt status clears latched bits
`ifndef LLC_CFG_SVH
`define LLC_CFG_SVH
`define LLC_ADDR_ENABLE     12'h004
`define LLC_ADDR_STATUS     12'h005
`define LLC_ADDR_IRQ_STATUS 12'h006
`define LLC_ADDR_MODE       12'h010
`define LLC_BIT_FIFO_LIMIT  5
`define LLC_BIT_LOOP_CODE   3
`define LLC_BIT_MODE_LOW    0
`define LLC_BIT_MODE_HIGH   1
`define LLC_FIFO_NEAR       6'd3
`define LLC_QUAL_SECONDS    5
`define LLC_LINE_RATE_HZ    2048000
`define LLC_QUAL_BITS       (`LLC_QUAL_SECONDS * `LLC_LINE_RATE_HZ)
`define LLC_RESP_OKAY       2'b00
`define LLC_RESP_SLVERR     2'b10
`endif

// ---- logic/llc_pkg.sv ----
// types for the line loop-code and fifo status block
package llc_pkg;
    typedef enum logic [1:0] {LLC_OFF, LLC_MAN_UP, LLC_MAN_DOWN, LLC_AUTO}
        llc_mode_t;
    typedef enum logic [1:0] {LLC_AUTO_SEEK_UP, LLC_AUTO_LOOPED}
        llc_auto_t;
    typedef struct packed {
        logic [2:0]  line_clk_sync;
        logic [1:0]  line_data_sync;
        logic [4:0]  hist;
        logic [23:0] up_cnt;
        logic [23:0] down_cnt;
        logic        up_seen;
        logic        down_seen;
        llc_auto_t   auto_st;
        logic        loopback;
        logic        loop_flag;
        logic        fifo_flag;
        logic [1:0]  mode_q;
        logic [7:0]  enable;
        logic        lc_latched;
        logic        fl_latched;
        logic        aw_pend;
        logic [11:0] aw_addr;
        logic        w_pend;
        logic [31:0] w_data;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } llc_state_t;
endpackage : llc_pkg

// ---- verification/llc_chk.sv ----
// bus and status checks for the loop-code block
`timescale 1ns/1ps
`default_nettype none
`include "llc_cfg.svh"
module llc_chk (
    input wire logic        CLK_SYS_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        REMOTE_LOOPBACK_OUT,
    input wire logic        IRQ_OUT,
    input wire logic        BVALID_OUT,
    input wire logic        BREADY_IN,
    input wire logic [1:0]  BRESP_OUT,
    input wire logic [11:0] ARADDR_IN,
    input wire logic        ARVALID_IN,
    input wire logic        ARREADY_OUT,
    input wire logic        RVALID_OUT,
    input wire logic        RREADY_IN,
    input wire logic [31:0] RDATA_OUT,
    input wire logic [1:0]  RRESP_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [11:0] a_q;
    wire logic st = a_q == (`LLC_ADDR_STATUS << 2);
    wire logic iq = a_q == (`LLC_ADDR_IRQ_STATUS << 2);
    wire logic mp = st || iq || a_q == (`LLC_ADDR_ENABLE << 2)
                    || a_q == (`LLC_ADDR_MODE << 2);
    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
        if (SYS_RST_IN) a_q <= '0;
        else if (ARVALID_IN && ARREADY_OUT) a_q <= ARADDR_IN;
    property p_r_hold;
        RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_b_hold;
        BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_ar;
        ARVALID_IN && ARREADY_OUT |=> RVALID_OUT;
    endproperty
    a_ar: assert property (p_ar) else $error("read answer late");
    property p_rresp;
        $rose(RVALID_OUT) |->
            RRESP_OUT == (mp ? `LLC_RESP_OKAY : `LLC_RESP_SLVERR);
    endproperty
    a_rresp: assert property (p_rresp) else $error("bad read response");
    property p_bit4;
        RVALID_OUT && st |-> !RDATA_OUT[4];
    endproperty
    a_bit4: assert property (p_bit4) else $error("unused bit set");
    property p_upper;
        RVALID_OUT && mp |-> RDATA_OUT[31:8] == '0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_loop;
        $rose(RVALID_OUT) && st && $past(REMOTE_LOOPBACK_OUT) |-> RDATA_OUT[3];
    endproperty
    a_loop: assert property (p_loop) else $error("flag low in loop");
    property p_irq;
        $rose(RVALID_OUT) && iq |->
            (RDATA_OUT[5] || RDATA_OUT[3]) == $past(IRQ_OUT);
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees");
endmodule : llc_chk
bind llc_top llc_chk llc_chk_inst (.*);
`default_nettype wire

// ---- verification/llc_line_model.sv ----
// far-end line source: free-running line clock and repeating codes
`timescale 1ns/1ps
`default_nettype none
module llc_line_model (
    input  wire logic [1:0] code_sel_in,
    output logic            line_clk_out,
    output logic            line_data_out
);
    int pos = 0;
    initial
    begin
        line_clk_out = 0;
        line_data_out = 0;
        forever #100 line_clk_out = ~line_clk_out;
    end
    // data moves on the falling edge, away from the sampling edge
    always @(negedge line_clk_out)
    begin
        pos <= pos + 1;
        case (code_sel_in)
            2'd1: line_data_out <= (pos % 5) == 4;
            2'd2: line_data_out <= (pos % 3) == 2;
            default: line_data_out <= pos[0];
        endcase
    end
endmodule : llc_line_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the loop-code and fifo status block
`timescale 1ns/1ps
`default_nettype none
`include "llc_cfg.svh"
module tb;
    localparam logic [11:0] EN = `LLC_ADDR_ENABLE << 2;
    localparam logic [11:0] ST = `LLC_ADDR_STATUS << 2;
    localparam logic [11:0] IS = `LLC_ADDR_IRQ_STATUS << 2;
    localparam logic [11:0] MD = `LLC_ADDR_MODE << 2;
    logic        clk = 0, rst = 1, lclk, ldat, aw_r, w_r, bv, ar_r, rv, lb, irq;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [5:0]  wp = 6'h20, rp = 6'h00;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0]  br, rr, code = 0;
    logic [7:0]  pf = 0;
    int          mismatches = 0, samples_checked = 0, cyc = 0, w, r;
    llc_line_model llc_line_model_inst (.code_sel_in(code),
        .line_clk_out(lclk), .line_data_out(ldat));
    llc_top #(.QUAL_BITS(40)) llc_top_inst (.CLK_SYS_IN(clk),
        .SYS_RST_IN(rst), .LINE_CLK_IN(lclk), .LINE_DATA_IN(ldat),
        .FIFO_WR_PTR_IN(wp), .FIFO_RD_PTR_IN(rp), .REMOTE_LOOPBACK_OUT(lb),
        .IRQ_OUT(irq), .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(aw_r),
        .WDATA_IN(wd), .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(w_r),
        .BRESP_OUT(br), .BVALID_OUT(bv), .BREADY_IN(bre), .ARADDR_IN(ara),
        .ARVALID_IN(arv), .ARREADY_OUT(ar_r), .RDATA_OUT(rdat),
        .RRESP_OUT(rr), .RVALID_OUT(rv), .RREADY_IN(rre));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [31:0] g, x);
        samples_checked++;
        if (g !== x)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        @(posedge clk);
        {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
        do
        begin
            @(posedge clk);
            if (aw_r) awv <= 0;
            if (w_r) wv <= 0;
        end while (!bv);
        bre <= 0;
        chk(br, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] m, x,
                      input logic [1:0] e = 0);
        @(posedge clk);
        {ara, arv, rre} <= {a, 2'b11};
        do
        begin
            @(posedge clk);
            if (ar_r) arv <= 0;
        end while (!rv);
        rre <= 0;
        chk(rdat & m, x);
        chk(rr, e);
    endtask : rd
    task automatic bits(input int n);
        repeat (n * 20) @(posedge clk);
    endtask : bits
    function automatic logic [7:0] fexp(input int a, b);
        int d = (a - b + 64) % 64;
        return (d <= 3 || d >= 61) ? 8'h20 : 8'h00;
    endfunction : fexp
    task complete_run;
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            mismatches++;
            complete_run();
        end
    end
    initial
    begin
        w = $urandom(37);
        repeat (20) @(posedge clk);
        rst <= 0;
        repeat (4) @(posedge clk);
        rd(ST, 8'h38, 0);
        rd(IS, 8'hff, 0);
        wr(EN, 32'h28, 0);
        wr(ST, 32'hff, 0);
        rd(ST, 8'h38, 0);
        wr(12'h100, 1, `LLC_RESP_SLVERR);
        rd(12'h100, 0, 0, `LLC_RESP_SLVERR);
        repeat (10)
        begin
            w = $urandom_range(0, 63);
            r = (w + $urandom_range(0, 8) + 60) % 64;
            {wp, rp} <= {6'(w), 6'(r)};
            repeat (10) @(posedge clk);
            rd(ST, 8'h38, fexp(w, r));
            chk(irq, fexp(w, r) != pf);
            rd(IS, 8'h20, fexp(w, r) ^ pf);
            pf = fexp(w, r);
        end
        for (int k = 1; k <= 2; k++)
        begin
            wr(MD, k, 0);
            code <= 2'(k);
            bits(20);
            rd(ST, 8'h08, 0);
            bits(40);
            rd(ST, 8'h08, 8'h08);
            chk(irq, 1);
            rd(IS, 8'h08, 8'h08);
            code <= 0;
            bits(6);
            rd(ST, 8'h08, 0);
            rd(IS, 8'h08, 8'h08);
        end
        code <= 2;
        bits(60);
        wr(MD, 3, 0);
        code <= 1;
        rd(ST, 8'h08, 0);
        bits(20);
        chk(lb, 0);
        bits(40);
        rd(ST, 8'h08, 8'h08);
        chk(lb, 1);
        code <= 0;
        bits(60);
        rd(ST, 8'h08, 8'h08);
        code <= 2;
        bits(20);
        chk(lb, 1);
        bits(40);
        rd(ST, 8'h08, 0);
        chk(lb, 0);
        rd(IS, 8'h08, 8'h08);
        complete_run();
    end
endmodule : tb
`default_nettype wire
